// *** include/clk_out_cfg.svh ***
// register offsets, field positions, reset values and codes of the clock output bank
`ifndef CLK_OUT_CFG_SVH
`define CLK_OUT_CFG_SVH

`define OUT_COUNT           8
`define REG_BASE            8'h77
`define REG_LAST            8'h9C
`define REG_COUNT           38

`define OFS_OUTPUT_ENABLE   8'h77
`define OFS_POLARITY        8'h78
`define OFS_STYLE_Q7_Q6     8'h79
`define OFS_STYLE_Q5_Q4     8'h7A
`define OFS_STYLE_Q3_Q2     8'h7B
`define OFS_STYLE_Q1_Q0     8'h7C
`define OFS_OUT0_S1         8'h7D
`define OFS_OUT0_S2_HI      8'h7E
`define OFS_OUT0_S2_LO      8'h7F
`define OFS_OUT1_S1         8'h80
`define OFS_OUT1_S2_HI      8'h81
`define OFS_OUT1_S2_LO      8'h82
`define OFS_OUT2_INT_TOP    8'h83
`define OFS_OUT2_INT_MID    8'h84
`define OFS_OUT2_INT_LOW    8'h85
`define OFS_OUT3_INT_TOP    8'h86
`define OFS_OUT3_INT_MID    8'h87
`define OFS_OUT3_INT_LOW    8'h88
`define OFS_OUT4_S1         8'h89
`define OFS_OUT4_S2_HI      8'h8A
`define OFS_OUT4_S2_LO      8'h8B
`define OFS_OUT5_S1         8'h8C
`define OFS_OUT5_S2_HI      8'h8D
`define OFS_OUT5_S2_LO      8'h8E
`define OFS_OUT6_S1         8'h8F
`define OFS_OUT6_S2_HI      8'h90
`define OFS_OUT6_S2_LO      8'h91
`define OFS_OUT7_S1         8'h92
`define OFS_OUT7_S2_HI      8'h93
`define OFS_OUT7_S2_LO      8'h94
`define OFS_OUT2_FRAC_B3    8'h95
`define OFS_OUT2_FRAC_B2    8'h96
`define OFS_OUT2_FRAC_B1    8'h97
`define OFS_OUT2_FRAC_B0    8'h98
`define OFS_OUT3_FRAC_B3    8'h99
`define OFS_OUT3_FRAC_B2    8'h9A
`define OFS_OUT3_FRAC_B1    8'h9B
`define OFS_OUT3_FRAC_B0    8'h9C

`define STYLE_HI_MSB        7
`define STYLE_HI_LSB        5
`define SE_HI_BIT           4
`define STYLE_LO_MSB        3
`define STYLE_LO_LSB        1
`define SE_LO_BIT           0
`define S1_MASK             8'h03
`define INT_TOP_MASK        8'h03
`define FRAC_TOP_MASK       8'h0F

`define STYLE_HIZ           3'h0
`define STYLE_LVPECL        3'h1
`define STYLE_LVDS          3'h2
`define STYLE_LVCMOS        3'h3
`define S1_DIV5             2'h0
`define S1_DIV6             2'h1
`define S1_DIV4             2'h2
`define INT_MIN_LEGAL       18'h00003

`define RST_OUTPUT_ENABLE   8'h0F
`define RST_POLARITY        8'h00
`define RST_STYLE_Q7_Q4     8'h22
`define RST_STYLE_Q3_Q0     8'h66
`define RST_OUT0_S1         2'h1
`define RST_OUT1_S1         2'h0
`define RST_OUTX_S1         2'h2
`define RST_OUT0_S2         16'h0002
`define RST_OUT1_S2         16'h0003
`define RST_OUTX_S2         16'h0000
`define RST_OUT2_INT        18'h00012
`define RST_OUT3_INT        18'h00048
`define RST_OUT2_FRAC       28'hC000000
`define RST_OUT3_FRAC       28'h1D89D8A

`endif

// *** include/clk_out_pkg.sv ***
// types shared by the clock output register bank and its dividers
package clk_out_pkg;
`include "clk_out_cfg.svh"

	typedef logic [7:0]                   byte_t;
	typedef logic [2:0]                   style_t;
	typedef logic [`REG_COUNT-1:0][7:0]   regbank_t;

	typedef struct packed {
		regbank_t                 regs;
		logic [17:0]              eff_int2;
		logic [17:0]              eff_int3;
		byte_t                    rdata;
		logic                     ack;
		logic [`OUT_COUNT-1:0]    q;
		logic [`OUT_COUNT-1:0]    nq;
		logic [`OUT_COUNT-1:0]    oe_n;
		logic [3*`OUT_COUNT-1:0]  style;
		logic [`OUT_COUNT-1:0]    se_fault;
		logic [1:0]               int_fault;
	} bank_state_t;

	typedef struct packed {
		logic [2:0]   s1_cnt;
		logic [16:0]  s2_cnt;
		logic [19:0]  f_cnt;
		logic [27:0]  acc;
		logic [1:0]   extra;
		logic         tick;
	} div_state_t;
endpackage

// *** logic/clk_out_divider.sv ***
// one output divider: two integer stages, or integer plus fraction
`timescale 1ns/1ps
module clk_out_divider #(
	parameter bit FRAC       = 1'b0,
	parameter bit CODE3_STOP = 1'b0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         src_tick_i,
	input  wire logic [1:0]   s1_code_i,
	input  wire logic [15:0]  s2_val_i,
	input  wire logic [17:0]  int_val_i,
	input  wire logic [27:0]  frac_val_i,
	output logic              tick_o
);
	import clk_out_pkg::*;

	div_state_t   s;
	div_state_t   n;

	// next state of the divider chain
	always_comb begin
		logic [2:0]   div1;
		logic         s1_tick;
		logic [19:0]  period;
		logic [29:0]  sum;
		div1    = 3'h5;
		s1_tick = 1'b0;
		period  = 20'h00000;
		sum     = 30'h00000000;
		n       = s;
		n.tick  = 1'b0;
		if (FRAC) begin
			// period is twice the integer part plus the carried fraction
			period = {1'b0, int_val_i, 1'b0} + {18'h00000, s.extra};
			if (src_tick_i) begin
				if (s.f_cnt + 20'h00001 >= period) begin
					n.f_cnt = 20'h00000;
					n.tick  = 1'b1;
					sum     = {2'h0, s.acc} + {1'b0, frac_val_i, 1'b0};
					n.acc   = sum[27:0];
					n.extra = sum[29:28];
				end else begin
					n.f_cnt = s.f_cnt + 20'h00001;
				end
			end
		end else begin
			case (s1_code_i)
				`S1_DIV5: div1 = 3'h5;
				`S1_DIV6: div1 = 3'h6;
				`S1_DIV4: div1 = 3'h4;
				default:  div1 = 3'h1;
			endcase
			// code 3 on the low outputs freezes the chain
			if (src_tick_i && !(CODE3_STOP && s1_code_i == 2'h3)) begin
				if (s.s1_cnt + 3'h1 >= div1) begin
					n.s1_cnt = 3'h0;
					s1_tick  = 1'b1;
				end else begin
					n.s1_cnt = s.s1_cnt + 3'h1;
				end
			end
			if (s1_tick) begin
				if (s2_val_i == 16'h0000) begin
					n.tick = 1'b1;
				end else if (s.s2_cnt + 17'h00001 >= {s2_val_i, 1'b0}) begin
					n.s2_cnt = 17'h00000;
					n.tick   = 1'b1;
				end else begin
					n.s2_cnt = s.s2_cnt + 17'h00001;
				end
			end
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick_o = s.tick;
endmodule

// *** logic/clk_out_bank.sv ***
// clock output driver and divider register bank with eight output pairs
//
// Summary of operation
// - An enable bit of zero floats its pair, one drives it in the chosen style; 0x0F at reset.
// - A polarity bit of one inverts its pair's clock, zero keeps it normal; all clear at reset.
// - Style code 000 floats, 001 LVPECL, 010 LVDS, 011 LVCMOS, others reserved; 0-3 LVCMOS, 4-7 LVPECL.
// - In LVCMOS the phase bit gives opposite phase at zero and equal phase at one; clear at reset.
// - First-stage code 00 divides by 5, 01 by 6, 10 by 4; 11 stops outputs 0-1 and divides by 1 on 4-7.
// - The second stage divides by twice its value, and a value of zero bypasses it.
// - The fractional outputs' integer part divides by twice its value and must not be 0, 1 or 2.
// - The fraction adds twice the fraction field times two to the minus 28 to the ratio.
`timescale 1ns/1ps
`include "clk_out_cfg.svh"
module clk_out_bank (
	input  wire logic                    CORE_CLK_I,
	input  wire logic                    RESET_N_I,
	input  wire logic [7:0]              REG_ADDR_I,
	input  wire logic                    REG_WR_I,
	input  wire clk_out_pkg::byte_t      REG_WDATA_I,
	input  wire logic                    REG_RD_I,
	output clk_out_pkg::byte_t           REG_RDATA_O,
	output logic                         REG_ACK_O,
	input  wire logic                    SRC_TICK_I,
	output logic [`OUT_COUNT-1:0]        Q_O,
	output logic [`OUT_COUNT-1:0]        NQ_O,
	output logic [`OUT_COUNT-1:0]        PAIR_OE_N_O,
	output logic [3*`OUT_COUNT-1:0]      DRIVER_STYLE_O,
	output logic [`OUT_COUNT-1:0]        PHASE_MISUSE_O,
	output logic [1:0]                   INT_DIV_ILLEGAL_O
);
	import clk_out_pkg::*;

	bank_state_t                s;
	bank_state_t                n;
	wire  [`OUT_COUNT-1:0]      div_tick;
	wire  [`OUT_COUNT-1:0][1:0] s1_code;
	wire  [`OUT_COUNT-1:0][15:0] s2_val;
	logic [17:0]                int2_prog;
	logic [17:0]                int3_prog;
	logic [27:0]                frac2;
	logic [27:0]                frac3;

	// byte map of the bank, lowest offset first
	// 0x77 enable bit of each pair
	// 0x78 polarity bit of each pair
	// 0x79 style and phase bit of pairs 7 (upper nibble) and 6
	// 0x7A style and phase bit of pairs 5 and 4
	// 0x7B style and phase bit of pairs 3 and 2
	// 0x7C style and phase bit of pairs 1 and 0
	// 0x7D output 0 first-stage code, bits 1:0
	// 0x7E output 0 second stage, upper byte
	// 0x7F output 0 second stage, lower byte
	// 0x80 output 1 first-stage code, bits 1:0
	// 0x81 output 1 second stage, upper byte
	// 0x82 output 1 second stage, lower byte
	// 0x83 output 2 integer part, bits 17:16
	// 0x84 output 2 integer part, bits 15:8
	// 0x85 output 2 integer part, bits 7:0
	// 0x86 output 3 integer part, bits 17:16
	// 0x87 output 3 integer part, bits 15:8
	// 0x88 output 3 integer part, bits 7:0
	// 0x89 output 4 first-stage code, bits 1:0
	// 0x8A output 4 second stage, upper byte
	// 0x8B output 4 second stage, lower byte
	// 0x8C output 5 first-stage code, bits 1:0
	// 0x8D output 5 second stage, upper byte
	// 0x8E output 5 second stage, lower byte
	// 0x8F output 6 first-stage code, bits 1:0
	// 0x90 output 6 second stage, upper byte
	// 0x91 output 6 second stage, lower byte
	// 0x92 output 7 first-stage code, bits 1:0
	// 0x93 output 7 second stage, upper byte
	// 0x94 output 7 second stage, lower byte
	// 0x95 output 2 fraction, bits 27:24
	// 0x96 output 2 fraction, bits 23:16
	// 0x97 output 2 fraction, bits 15:8
	// 0x98 output 2 fraction, bits 7:0
	// 0x99 output 3 fraction, bits 27:24
	// 0x9A output 3 fraction, bits 23:16
	// 0x9B output 3 fraction, bits 15:8
	// 0x9C output 3 fraction, bits 7:0
	// reserved bits of every byte are dropped on write and read as zero

	// byte index of an offset inside the bank
	function automatic int unsigned ix(input byte_t ofs);
		ix = int'(ofs - `REG_BASE);
	endfunction

	// writable bits of each byte, reserved bits stay zero
	function automatic byte_t wmask(input byte_t ofs);
		if (ofs == `OFS_OUT0_S1 || ofs == `OFS_OUT1_S1) begin
			wmask = `S1_MASK;
		end else if (ofs == `OFS_OUT4_S1 || ofs == `OFS_OUT5_S1) begin
			wmask = `S1_MASK;
		end else if (ofs == `OFS_OUT6_S1 || ofs == `OFS_OUT7_S1) begin
			wmask = `S1_MASK;
		end else if (ofs == `OFS_OUT2_INT_TOP || ofs == `OFS_OUT3_INT_TOP) begin
			wmask = `INT_TOP_MASK;
		end else if (ofs == `OFS_OUT2_FRAC_B3 || ofs == `OFS_OUT3_FRAC_B3) begin
			wmask = `FRAC_TOP_MASK;
		end else begin
			wmask = 8'hFF;
		end
	endfunction

	// offset of the first-stage byte of an integer output
	function automatic byte_t s1_ofs(input int unsigned m);
		case (m)
			0:       s1_ofs = `OFS_OUT0_S1;
			1:       s1_ofs = `OFS_OUT1_S1;
			4:       s1_ofs = `OFS_OUT4_S1;
			5:       s1_ofs = `OFS_OUT5_S1;
			6:       s1_ofs = `OFS_OUT6_S1;
			default: s1_ofs = `OFS_OUT7_S1;
		endcase
	endfunction

	// offset of the high second-stage byte of an integer output
	function automatic byte_t s2hi_ofs(input int unsigned m);
		case (m)
			0:       s2hi_ofs = `OFS_OUT0_S2_HI;
			1:       s2hi_ofs = `OFS_OUT1_S2_HI;
			4:       s2hi_ofs = `OFS_OUT4_S2_HI;
			5:       s2hi_ofs = `OFS_OUT5_S2_HI;
			6:       s2hi_ofs = `OFS_OUT6_S2_HI;
			default: s2hi_ofs = `OFS_OUT7_S2_HI;
		endcase
	endfunction

	// offset of the low second-stage byte of an integer output
	function automatic byte_t s2lo_ofs(input int unsigned m);
		case (m)
			0:       s2lo_ofs = `OFS_OUT0_S2_LO;
			1:       s2lo_ofs = `OFS_OUT1_S2_LO;
			4:       s2lo_ofs = `OFS_OUT4_S2_LO;
			5:       s2lo_ofs = `OFS_OUT5_S2_LO;
			6:       s2lo_ofs = `OFS_OUT6_S2_LO;
			default: s2lo_ofs = `OFS_OUT7_S2_LO;
		endcase
	endfunction

	// style byte shared by a pair of outputs
	function automatic byte_t style_byte(input regbank_t r, input int unsigned m);
		case (m / 2)
			0:       style_byte = r[ix(`OFS_STYLE_Q1_Q0)];
			1:       style_byte = r[ix(`OFS_STYLE_Q3_Q2)];
			2:       style_byte = r[ix(`OFS_STYLE_Q5_Q4)];
			default: style_byte = r[ix(`OFS_STYLE_Q7_Q6)];
		endcase
	endfunction

	// driver style field of one output
	function automatic style_t style_of(input regbank_t r, input int unsigned m);
		byte_t b;
		b = style_byte(r, m);
		if (m % 2 == 1) begin
			style_of = b[`STYLE_HI_MSB:`STYLE_HI_LSB];
		end else begin
			style_of = b[`STYLE_LO_MSB:`STYLE_LO_LSB];
		end
	endfunction

	// single-ended phase bit of one output
	function automatic logic se_of(input regbank_t r, input int unsigned m);
		byte_t b;
		b = style_byte(r, m);
		se_of = (m % 2 == 1) ? b[`SE_HI_BIT] : b[`SE_LO_BIT];
	endfunction

	// power-up contents of the whole bank
	function automatic regbank_t reset_bank();
		regbank_t r;
		r = '0;
		r[ix(`OFS_OUTPUT_ENABLE)] = `RST_OUTPUT_ENABLE;
		r[ix(`OFS_POLARITY)]      = `RST_POLARITY;
		r[ix(`OFS_STYLE_Q7_Q6)]   = `RST_STYLE_Q7_Q4;
		r[ix(`OFS_STYLE_Q5_Q4)]   = `RST_STYLE_Q7_Q4;
		r[ix(`OFS_STYLE_Q3_Q2)]   = `RST_STYLE_Q3_Q0;
		r[ix(`OFS_STYLE_Q1_Q0)]   = `RST_STYLE_Q3_Q0;
		r[ix(`OFS_OUT0_S1)]       = {6'h00, `RST_OUT0_S1};
		r[ix(`OFS_OUT1_S1)]       = {6'h00, `RST_OUT1_S1};
		r[ix(`OFS_OUT4_S1)]       = {6'h00, `RST_OUTX_S1};
		r[ix(`OFS_OUT5_S1)]       = {6'h00, `RST_OUTX_S1};
		r[ix(`OFS_OUT6_S1)]       = {6'h00, `RST_OUTX_S1};
		r[ix(`OFS_OUT7_S1)]       = {6'h00, `RST_OUTX_S1};
		r[ix(`OFS_OUT0_S2_HI)]    = 8'(`RST_OUT0_S2 >> 8);
		r[ix(`OFS_OUT0_S2_LO)]    = 8'(`RST_OUT0_S2 & 16'h00FF);
		r[ix(`OFS_OUT1_S2_HI)]    = 8'(`RST_OUT1_S2 >> 8);
		r[ix(`OFS_OUT1_S2_LO)]    = 8'(`RST_OUT1_S2 & 16'h00FF);
		r[ix(`OFS_OUT2_INT_TOP)]  = 8'(`RST_OUT2_INT >> 16);
		r[ix(`OFS_OUT2_INT_MID)]  = 8'((`RST_OUT2_INT >> 8) & 18'h000FF);
		r[ix(`OFS_OUT2_INT_LOW)]  = 8'(`RST_OUT2_INT & 18'h000FF);
		r[ix(`OFS_OUT3_INT_TOP)]  = 8'(`RST_OUT3_INT >> 16);
		r[ix(`OFS_OUT3_INT_MID)]  = 8'((`RST_OUT3_INT >> 8) & 18'h000FF);
		r[ix(`OFS_OUT3_INT_LOW)]  = 8'(`RST_OUT3_INT & 18'h000FF);
		r[ix(`OFS_OUT2_FRAC_B3)]  = 8'(`RST_OUT2_FRAC >> 24);
		r[ix(`OFS_OUT2_FRAC_B2)]  = 8'((`RST_OUT2_FRAC >> 16) & 28'h00000FF);
		r[ix(`OFS_OUT2_FRAC_B1)]  = 8'((`RST_OUT2_FRAC >> 8) & 28'h00000FF);
		r[ix(`OFS_OUT2_FRAC_B0)]  = 8'(`RST_OUT2_FRAC & 28'h00000FF);
		r[ix(`OFS_OUT3_FRAC_B3)]  = 8'(`RST_OUT3_FRAC >> 24);
		r[ix(`OFS_OUT3_FRAC_B2)]  = 8'((`RST_OUT3_FRAC >> 16) & 28'h00000FF);
		r[ix(`OFS_OUT3_FRAC_B1)]  = 8'((`RST_OUT3_FRAC >> 8) & 28'h00000FF);
		r[ix(`OFS_OUT3_FRAC_B0)]  = 8'(`RST_OUT3_FRAC & 28'h00000FF);
		reset_bank = r;
	endfunction

	// power-up contents as a constant, so the reset branch loads constants only
	localparam regbank_t RST_BANK = reset_bank();

	// multi-byte fields, most significant byte at the lowest address
	assign int2_prog = {s.regs[ix(`OFS_OUT2_INT_TOP)][1:0], s.regs[ix(`OFS_OUT2_INT_MID)],
	                    s.regs[ix(`OFS_OUT2_INT_LOW)]};
	assign int3_prog = {s.regs[ix(`OFS_OUT3_INT_TOP)][1:0], s.regs[ix(`OFS_OUT3_INT_MID)],
	                    s.regs[ix(`OFS_OUT3_INT_LOW)]};
	assign frac2     = {s.regs[ix(`OFS_OUT2_FRAC_B3)][3:0], s.regs[ix(`OFS_OUT2_FRAC_B2)],
	                    s.regs[ix(`OFS_OUT2_FRAC_B1)], s.regs[ix(`OFS_OUT2_FRAC_B0)]};
	assign frac3     = {s.regs[ix(`OFS_OUT3_FRAC_B3)][3:0], s.regs[ix(`OFS_OUT3_FRAC_B2)],
	                    s.regs[ix(`OFS_OUT3_FRAC_B1)], s.regs[ix(`OFS_OUT3_FRAC_B0)]};

	// one divider per output; outputs 2 and 3 take the fractional path
	genvar g;
	generate
		for (g = 0; g < `OUT_COUNT; g++) begin : g_out
			if (g == 2 || g == 3) begin : g_frac
				assign s1_code[g] = 2'h0;
				assign s2_val[g]  = 16'h0000;
				clk_out_divider #(
					.FRAC       (1'b1),
					.CODE3_STOP (1'b0)
				) u_div (
					.clk_i      (CORE_CLK_I),
					.rst_n_i    (RESET_N_I),
					.src_tick_i (SRC_TICK_I),
					.s1_code_i  (s1_code[g]),
					.s2_val_i   (s2_val[g]),
					.int_val_i  ((g == 2) ? s.eff_int2 : s.eff_int3),
					.frac_val_i ((g == 2) ? frac2 : frac3),
					.tick_o     (div_tick[g])
				);
			end else begin : g_int
				assign s1_code[g] = s.regs[ix(s1_ofs(g))][1:0];
				assign s2_val[g]  = {s.regs[ix(s2hi_ofs(g))], s.regs[ix(s2lo_ofs(g))]};
				clk_out_divider #(
					.FRAC       (1'b0),
					.CODE3_STOP (g < 2)
				) u_div (
					.clk_i      (CORE_CLK_I),
					.rst_n_i    (RESET_N_I),
					.src_tick_i (SRC_TICK_I),
					.s1_code_i  (s1_code[g]),
					.s2_val_i   (s2_val[g]),
					.int_val_i  (18'h00000),
					.frac_val_i (28'h0000000),
					.tick_o     (div_tick[g])
				);
			end
		end
	endgenerate

	// register access, divider guard and pin drive
	always_comb begin
		byte_t   idx;
		logic    hit;
		logic    lvl;
		style_t  st;
		idx = REG_ADDR_I - `REG_BASE;
		hit = (REG_ADDR_I >= `REG_BASE) && (REG_ADDR_I <= `REG_LAST);
		lvl = 1'b0;
		st  = `STYLE_HIZ;
		// hold everything unless a request or the pins change it
		n   = s;
		n.ack = REG_WR_I || REG_RD_I;
		// write path, reserved bits masked off
		if (REG_WR_I && hit) begin
			n.regs[idx] = REG_WDATA_I & wmask(REG_ADDR_I);
		end
		// read path, unmapped offsets read zero
		if (REG_RD_I) begin
			n.rdata = hit ? s.regs[idx] : 8'h00;
		end
		// an illegal integer part keeps the last legal one in use
		n.int_fault[0] = int2_prog < `INT_MIN_LEGAL;
		n.int_fault[1] = int3_prog < `INT_MIN_LEGAL;
		if (int2_prog >= `INT_MIN_LEGAL) begin
			n.eff_int2 = int2_prog;
		end
		if (int3_prog >= `INT_MIN_LEGAL) begin
			n.eff_int3 = int3_prog;
		end
		// per-pair style, phase fault and pin drive
		for (int unsigned m = 0; m < `OUT_COUNT; m++) begin
			lvl = div_tick[m] ^ s.regs[ix(`OFS_POLARITY)][m];
			st  = style_of(s.regs, m);
			n.style[3*m +: 3] = st;
			n.se_fault[m] = se_of(s.regs, m) &&
			                (st == `STYLE_LVPECL || st == `STYLE_LVDS);
			n.q[m]    = 1'b0;
			n.nq[m]   = 1'b0;
			n.oe_n[m] = 1'b1;
			if (s.regs[ix(`OFS_OUTPUT_ENABLE)][m]) begin
				case (st)
					`STYLE_LVPECL, `STYLE_LVDS: begin
						n.q[m]    = lvl;
						n.nq[m]   = ~lvl;
						n.oe_n[m] = 1'b0;
					end
					`STYLE_LVCMOS: begin
						n.q[m]    = lvl;
						n.nq[m]   = se_of(s.regs, m) ? lvl : ~lvl;
						n.oe_n[m] = 1'b0;
					end
					default: begin
						n.oe_n[m] = 1'b1;
					end
				endcase
			end
		end
	end

	// state register with power-up contents
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			s           <= '0;
			s.regs      <= RST_BANK;
			s.eff_int2  <= `RST_OUT2_INT;
			s.eff_int3  <= `RST_OUT3_INT;
			s.oe_n      <= '1;
		end else begin
			s <= n;
		end
	end

	// outputs straight from the state register
	assign REG_RDATA_O       = s.rdata;
	assign REG_ACK_O         = s.ack;
	assign Q_O               = s.q;
	assign NQ_O              = s.nq;
	assign PAIR_OE_N_O       = s.oe_n;
	assign DRIVER_STYLE_O    = s.style;
	assign PHASE_MISUSE_O    = s.se_fault;
	assign INT_DIV_ILLEGAL_O = s.int_fault;
endmodule

// *** test/clk_out_bank_monitor.sv ***
// concurrent checks on the ports of the clock output register bank
`timescale 1ns/1ps
module clk_out_bank_monitor (
	input wire logic                CORE_CLK_I,
	input wire logic                RESET_N_I,
	input wire logic [7:0]          REG_ADDR_I,
	input wire logic                REG_WR_I,
	input wire clk_out_pkg::byte_t  REG_WDATA_I,
	input wire logic                REG_RD_I,
	input wire clk_out_pkg::byte_t  REG_RDATA_O,
	input wire logic                REG_ACK_O,
	input wire logic                SRC_TICK_I,
	input wire logic [7:0]          Q_O,
	input wire logic [7:0]          NQ_O,
	input wire logic [7:0]          PAIR_OE_N_O,
	input wire logic [23:0]         DRIVER_STYLE_O,
	input wire logic [7:0]          PHASE_MISUSE_O,
	input wire logic [1:0]          INT_DIV_ILLEGAL_O
);
	logic [7:0] float_m;
	logic [7:0] diff_m;

	// pairs whose style floats them, and pairs driven differentially
	always_comb begin
		for (int m = 0; m < 8; m++) begin
			float_m[m] = (DRIVER_STYLE_O[3*m +: 3] == 3'h0) || DRIVER_STYLE_O[3*m+2];
			diff_m[m]  = (DRIVER_STYLE_O[3*m +: 3] == 3'h1) || (DRIVER_STYLE_O[3*m +: 3] == 3'h2);
		end
	end

	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	// bus request and the two read cases of interest
	sequence s_strobe;
		REG_WR_I || REG_RD_I;
	endsequence
	sequence s_bad_read;
		REG_RD_I && ((REG_ADDR_I < 8'h77) || (REG_ADDR_I > 8'h9C));
	endsequence
	sequence s_s1_read;
		REG_RD_I && (REG_ADDR_I inside {8'h7D, 8'h80, 8'h89, 8'h8C, 8'h8F, 8'h92});
	endsequence

	// a cleared enable bit must leave its pair floating two edges on
	property p_enable_off;
		logic [7:0] d;
		(REG_WR_I && REG_ADDR_I == 8'h77, d = REG_WDATA_I) ##1 !(REG_WR_I && REG_ADDR_I == 8'h77)
			|=> ((~PAIR_OE_N_O) & ~d) == 8'h00;
	endproperty

	a_ack_follows: assert property (s_strobe |=> REG_ACK_O) else $error("ack missing after strobe");
	a_ack_cause: assert property (REG_ACK_O |-> $past(REG_WR_I || REG_RD_I))
		else $error("ack without a strobe");
	a_rdata_holds: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (s_bad_read |=> REG_RDATA_O == 8'h00)
		else $error("unmapped read not zero");
	a_rsvd_masked: assert property (s_s1_read |=> REG_RDATA_O[7:2] == 6'h00)
		else $error("reserved divider bits read back");
	a_enable_off: assert property (p_enable_off) else $error("disabled pair still driven");
	a_style_float: assert property ((PAIR_OE_N_O & float_m) == float_m)
		else $error("floating style pair driven");
	a_off_silent: assert property (((Q_O | NQ_O) & PAIR_OE_N_O) == 8'h00)
		else $error("floating pair shows activity");
	a_diff_compl: assert property (((Q_O ^ NQ_O) | ~diff_m | PAIR_OE_N_O) == 8'hFF)
		else $error("differential pins not complementary");
	a_reset_style: assert property ($rose(RESET_N_I) |=> DRIVER_STYLE_O == 24'h2496DB)
		else $error("style defaults wrong after reset");
endmodule

bind clk_out_bank clk_out_bank_monitor i_mon (
	.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .REG_ADDR_I(REG_ADDR_I),
	.REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O), .REG_ACK_O(REG_ACK_O), .SRC_TICK_I(SRC_TICK_I),
	.Q_O(Q_O), .NQ_O(NQ_O), .PAIR_OE_N_O(PAIR_OE_N_O), .DRIVER_STYLE_O(DRIVER_STYLE_O),
	.PHASE_MISUSE_O(PHASE_MISUSE_O), .INT_DIV_ILLEGAL_O(INT_DIV_ILLEGAL_O)
);

// *** test/clk_out_bank_test.sv ***
// self-checking bench of the clock output register bank
`timescale 1ns/1ps
module clk_out_bank_test;
	import clk_out_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	localparam row_t ROWS [10] = '{'{8'h77, 8'hA5, 8'hA5}, '{8'h78, 8'h3C, 8'h3C},
		'{8'h7D, 8'hFF, 8'h03}, '{8'h83, 8'hFF, 8'h03}, '{8'h92, 8'hFF, 8'h03},
		'{8'h95, 8'hFF, 8'h0F}, '{8'h99, 8'hF1, 8'h01}, '{8'h9C, 8'h5A, 8'h5A},
		'{8'h9D, 8'hFF, 8'h00}, '{8'h76, 8'hFF, 8'h00}};
	localparam logic [7:0] DFLT [38] = '{8'h0F, 8'h00, 8'h22, 8'h22, 8'h66, 8'h66,
		8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h12, 8'h00, 8'h00, 8'h48,
		8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
		8'h0C, 8'h00, 8'h00, 8'h00, 8'h01, 8'hD8, 8'h9D, 8'h8A};
	localparam int PER [4] = '{5, 6, 4, 1};
	logic        clk;
	logic        rst_n;
	logic        wr_en;
	logic        rd_en;
	logic        tick;
	logic [7:0]  addr;
	byte_t       wdata;
	byte_t       rdata;
	logic        ack;
	logic [7:0]  q;
	logic [7:0]  nq;
	logic [7:0]  oe_n;
	logic [23:0] style;
	logic [7:0]  misuse;
	logic [1:0]  ill;
	logic [7:0]  v;
	int          h;
	int          error_cnt;
	int          num_checks;
	int          cyc;

	clk_out_bank i_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .REG_ADDR_I(addr), .REG_WR_I(wr_en),
		.REG_WDATA_I(wdata), .REG_RD_I(rd_en), .REG_RDATA_O(rdata), .REG_ACK_O(ack),
		.SRC_TICK_I(tick), .Q_O(q), .NQ_O(nq), .PAIR_OE_N_O(oe_n), .DRIVER_STYLE_O(style),
		.PHASE_MISUSE_O(misuse), .INT_DIV_ILLEGAL_O(ill));

	// free-running clock
	always #4 clk = ~clk;

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		chk(ack, 1'b1);
		@(negedge clk);
		r = rdata;
	endtask

	// counts cycles with the true pin of pair i high after a settling pause
	task automatic cnt(input int i, input int n, output int hc);
		hc = 0;
		repeat (40) @(negedge clk);
		repeat (n) begin
			@(negedge clk);
			if (q[i] === 1'b1) hc++;
		end
	endtask

	task automatic do_reset;
		rst_n = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
	endtask

	task automatic results;
		if (error_cnt == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		tick = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		error_cnt = 0;
		num_checks = 0;
		cyc = 0;
		do_reset();
		@(negedge clk);
		chk(oe_n, 8'hF0);
		chk(style, 24'h2496DB);
		for (int j = 0; j < 38; j++) begin
			rd(8'h77 + j[7:0], v);
			chk(v, DFLT[j]);
		end
		// write and read-back rows, reserved bits and unmapped offsets included
		for (int j = 0; j < 10; j++) begin
			wr(ROWS[j].a, ROWS[j].d);
			rd(ROWS[j].a, v);
			chk(v, ROWS[j].e);
		end
		do_reset();
		rd(8'h77, v);
		chk(v, 8'h0F);
		wr(8'h77, 8'hFF);
		// every first-stage code on integer output 4, second stage bypassed
		for (int j = 0; j < 4; j++) begin
			wr(8'h89, j[7:0]);
			cnt(4, 60, h);
			chk(h, 60 / PER[j]);
		end
		wr(8'h89, 8'h02);
		wr(8'h8A, 8'h00);
		wr(8'h8B, 8'h03);
		cnt(4, 48, h);
		chk(h, 2);
		tick = 1'b0;
		cnt(4, 48, h);
		chk(h, 0);
		tick = 1'b1;
		wr(8'h78, 8'h10);
		cnt(4, 48, h);
		chk(h, 46);
		wr(8'h7D, 8'h03);
		cnt(0, 60, h);
		chk(h, 0);
		chk(nq[0], 1'b1);
		wr(8'h7C, 8'h76);
		cnt(1, 60, h);
		chk(h, 2);
		h = 0;
		repeat (60) begin
			@(negedge clk);
			if (q[1] !== nq[1]) h++;
		end
		chk(h, 0);
		wr(8'h7A, 8'h52);
		@(negedge clk);
		chk(misuse, 8'h20);
		// all style codes on pair 0
		for (int j = 0; j < 8; j++) begin
			wr(8'h7C, {4'h7, j[2:0], 1'b0});
			@(negedge clk);
			chk(style[2:0], j[2:0]);
			chk(oe_n[0], (j == 0 || j > 3));
		end
		wr(8'h83, 8'h00);
		wr(8'h84, 8'h00);
		wr(8'h85, 8'h01);
		@(negedge clk);
		chk(ill, 2'b01);
		rd(8'h85, v);
		chk(v, 8'h01);
		wr(8'h85, 8'h03);
		@(negedge clk);
		chk(ill, 2'b00);
		wr(8'h95, 8'h00);
		cnt(2, 60, h);
		chk(h, 10);
		wr(8'h95, 8'h08);
		cnt(2, 70, h);
		chk(h, 10);
		results();
	end
endmodule
